// *** design/crc8_tree.sv ***
`default_nettype none
module crc8_tree
   import crc_chop4_pkg::*;
(
   // Tree inputs
   input wire logic [TREE_INPUTS-1:0] tree_in,
   // Check bits
   output logic [CHECK_BITS-1:0] check_out
);
   // ==========================================
   // Parallel CRC-8 as a fixed XOR network
   function automatic logic [CHECK_BITS-1:0] crc8_calc(input logic [TREE_INPUTS-1:0] d);
      logic [CHECK_BITS-1:0] c;
      logic fb;
      c = CRC_INIT;
      fb = 1'b0;
      for (int i = TREE_INPUTS - 1; i >= 0; i--) begin
         fb = c[CHECK_BITS-1] ^ d[i];
         c = {c[CHECK_BITS-2:0], 1'b0};
         if (fb) begin
            c = c ^ CRC_POLY;
         end
      end
      return c;
   endfunction : crc8_calc

   assign check_out = crc8_calc(tree_in);
endmodule : crc8_tree
`default_nettype wire

// *** design/crc_chop4_pkg.sv ***
`default_nettype none
package crc_chop4_pkg;
   // ==========================================
   // Geometry
   localparam int TREE_INPUTS = 72;
   localparam int TREE_USED_INPUTS = 36;
   localparam int CHECK_BITS = 8;
   localparam int LANES_PER_TREE = 8;
   localparam int DQ_LANES = 16;
   localparam int CHOP_BEATS = 4;
   localparam logic [3:0] CHECK_BEAT = 4'h8;
   localparam logic [3:0] LAST_BEAT = 4'h9;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;
   // ==========================================
   // Register map (byte addresses)
   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] STATUS_ADDR = 12'h004;
   localparam logic [11:0] CHECK_ADDR = 12'h008;
   localparam logic [11:0] ERRCNT_ADDR = 12'h00C;
   // CTRL fields
   localparam int CTRL_CRC_EN = 0;
   localparam int CTRL_CHOP_FIXED = 1;
   localparam int CTRL_OTF_ALLOWED = 2;
   localparam int CTRL_MASK_EN = 3;
   localparam int CTRL_INVERT_EN = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // STATUS fields
   localparam int STAT_ERROR = 0;
   localparam int STAT_UPPER_HALF = 1;
   localparam int STAT_ACTIVE = 2;
   localparam int STAT_BUSY = 8;
   // ==========================================
   // Receive states
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_BEATS = 2'b01,
      RX_CHECK = 2'b11
   } rx_state_type;
endpackage : crc_chop4_pkg
`default_nettype wire

// *** design/write_crc_x16_chop4_map.sv ***
// What this block does
// - Two identical trees, each with 36 live inputs and eight check bits.
// - Nibble bit low: lane n beat k is input 8n+k; beats 4-7 are ones.
// - Nibble bit high: received upper nibbles fill the lower nibble positions.
// - Nibble bit low: inputs 64-67 from wire if mask/inversion on, else ones.
// - Nibble bit low: inputs 136-139 from wire if mask/inversion on, else ones.
// - Nibble bit high: inputs 64-67 from wire if enabled, else ones.
// - Nibble bit high: inputs 136-139 from wire if enabled, else ones.
// - Each check bit is an XOR of fixed inputs; padded ones enter as ones.
// - Lower tree gives bits 7-0 over 71-0, upper 15-8 over 143-72.
// - Active only with CRC on, fixed chop on, on-the-fly chop off.
`default_nettype none
module write_crc_x16_chop4_map
   import crc_chop4_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   // APB slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // Write burst from the link
   input wire logic BURST_START_IN,
   input wire logic BEAT_VALID_IN,
   input wire logic NIBBLE_SELECT_ADDR_BIT_IN,
   input wire logic [DQ_LANES-1:0] DQ_IN,
   input wire logic LOWER_LANE_MASK_INVERT_IN,
   input wire logic UPPER_LANE_MASK_INVERT_IN,
   // Received data and check result
   output logic [CHOP_BEATS*DQ_LANES-1:0] DATA_OUT,
   output logic [2*CHOP_BEATS-1:0] MASK_INVERT_OUT,
   output logic UPPER_HALF_OUT,
   output logic DATA_VALID_OUT,
   output logic CRC_ERROR_OUT
);
   // ==========================================
   // Registers and state
   logic [4:0] ctrl;
   logic error_flag;
   logic [15:0] err_count;
   logic [15:0] calc_crc;
   logic [15:0] rx_crc;
   logic upper_half;
   rx_state_type rx_state;
   rx_state_type next_rx_state;
   logic [3:0] beat_idx;
   logic [DQ_LANES-1:0] beat_dq [CHOP_BEATS];
   logic [1:0] beat_mi [CHOP_BEATS];
   logic [TREE_INPUTS-1:0] tree_in [2];
   logic [CHECK_BITS-1:0] tree_out [2];
   logic map_active;
   logic mi_used;
   logic mismatch;
   logic check_done;
   logic apb_wr;
   logic apb_rd_ok;

   assign map_active = ctrl[CTRL_CRC_EN] & ctrl[CTRL_CHOP_FIXED] & ~ctrl[CTRL_OTF_ALLOWED];
   assign mi_used = ctrl[CTRL_MASK_EN] | ctrl[CTRL_INVERT_EN];

   // ==========================================
   // APB access
   function automatic logic addr_mapped(input logic [11:0] a);
      return (a == CTRL_ADDR) || (a == STATUS_ADDR) || (a == CHECK_ADDR) || (a == ERRCNT_ADDR);
   endfunction : addr_mapped

   assign PREADY_OUT = 1'b1;
   assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_mapped(PADDR_IN);
   assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & addr_mapped(PADDR_IN);
   assign apb_rd_ok = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN & addr_mapped(PADDR_IN);

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ctrl <= CTRL_RESET;
      end else if (apb_wr && PADDR_IN == CTRL_ADDR) begin
         ctrl <= PWDATA_IN[4:0];
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         PRDATA_OUT <= 32'h0000_0000;
      end else if (apb_rd_ok) begin
         case (PADDR_IN)
            CTRL_ADDR: PRDATA_OUT <= {27'h000_0000, ctrl};
            STATUS_ADDR: PRDATA_OUT <= {23'h00_0000, (rx_state != RX_IDLE), 5'h00, map_active, upper_half,
                                        error_flag};
            CHECK_ADDR: PRDATA_OUT <= {rx_crc, calc_crc};
            ERRCNT_ADDR: PRDATA_OUT <= {16'h0000, err_count};
            default: PRDATA_OUT <= 32'h0000_0000;
         endcase
      end else if (PSEL_IN && !PENABLE_IN) begin
         PRDATA_OUT <= 32'h0000_0000;
      end
   end

   // ==========================================
   // Burst receive sequencing
   always_comb begin
      next_rx_state = rx_state;
      case (rx_state)
         RX_IDLE: begin
            if (BURST_START_IN && BEAT_VALID_IN && map_active) begin
               next_rx_state = RX_BEATS;
            end
         end
         RX_BEATS: begin
            if (BEAT_VALID_IN && beat_idx == LAST_BEAT) begin
               next_rx_state = RX_CHECK;
            end
         end
         RX_CHECK: next_rx_state = RX_IDLE;
         default: next_rx_state = RX_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rx_state <= RX_IDLE;
         beat_idx <= 4'h0;
      end else begin
         rx_state <= next_rx_state;
         if (rx_state == RX_IDLE && next_rx_state == RX_BEATS) begin
            beat_idx <= 4'h1;
         end else if (rx_state == RX_BEATS && BEAT_VALID_IN) begin
            beat_idx <= beat_idx + 4'h1;
         end
      end
   end

   // Beats 0-3 carry data, beat 8 check bits, beat 9 padding
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         for (int b = 0; b < CHOP_BEATS; b++) begin
            beat_dq[b] <= 16'h0000;
            beat_mi[b] <= 2'b00;
         end
         rx_crc <= 16'h0000;
         upper_half <= 1'b0;
      end else if (BEAT_VALID_IN) begin
         if (rx_state == RX_IDLE && next_rx_state == RX_BEATS) begin
            beat_dq[0] <= DQ_IN;
            beat_mi[0] <= {UPPER_LANE_MASK_INVERT_IN, LOWER_LANE_MASK_INVERT_IN};
            upper_half <= NIBBLE_SELECT_ADDR_BIT_IN;
         end else if (rx_state == RX_BEATS && beat_idx < 4'(CHOP_BEATS)) begin
            beat_dq[beat_idx[1:0]] <= DQ_IN;
            beat_mi[beat_idx[1:0]] <= {UPPER_LANE_MASK_INVERT_IN, LOWER_LANE_MASK_INVERT_IN};
         end else if (rx_state == RX_BEATS && beat_idx == CHECK_BEAT) begin
            rx_crc <= DQ_IN;
         end
      end
   end

   // ==========================================
   // Tree input mapping
   // Either half lands in nibble positions 3:0 of each group; 7:4 pad to ones.
   generate
      for (genvar t = 0; t < 2; t++) begin : g_tree
         for (genvar j = 0; j < LANES_PER_TREE; j++) begin : g_lane
            for (genvar k = 0; k < LANES_PER_TREE; k++) begin : g_bit
               if (k < CHOP_BEATS) begin : g_live
                  assign tree_in[t][8*j+k] = beat_dq[k][t*LANES_PER_TREE+j];
               end else begin : g_pad
                  assign tree_in[t][8*j+k] = 1'b1;
               end
            end
         end
         for (genvar k = 0; k < LANES_PER_TREE; k++) begin : g_mi
            if (k < CHOP_BEATS) begin : g_live
               // Lower tree: lower lane bit; upper tree: upper lane bit
               assign tree_in[t][8*LANES_PER_TREE+k] = mi_used ? beat_mi[k][t] : 1'b1;
            end else begin : g_pad
               assign tree_in[t][8*LANES_PER_TREE+k] = 1'b1;
            end
         end
         crc8_tree u_tree (
            .tree_in(tree_in[t]),
            .check_out(tree_out[t])
         );
      end
   endgenerate

   assign mismatch = ({tree_out[1], tree_out[0]} != rx_crc);
   assign check_done = (rx_state == RX_CHECK);

   // ==========================================
   // Check result
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         calc_crc <= 16'h0000;
         CRC_ERROR_OUT <= 1'b0;
         DATA_VALID_OUT <= 1'b0;
         DATA_OUT <= 64'h0000_0000_0000_0000;
         MASK_INVERT_OUT <= 8'h00;
         UPPER_HALF_OUT <= 1'b0;
      end else begin
         CRC_ERROR_OUT <= check_done & mismatch;
         DATA_VALID_OUT <= check_done;
         if (check_done) begin
            calc_crc <= {tree_out[1], tree_out[0]};
            DATA_OUT <= {beat_dq[3], beat_dq[2], beat_dq[1], beat_dq[0]};
            MASK_INVERT_OUT <= {beat_mi[3], beat_mi[2], beat_mi[1], beat_mi[0]};
            UPPER_HALF_OUT <= upper_half;
         end
      end
   end

   // Sticky error, write one to clear; a new error wins over the clear
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         error_flag <= 1'b0;
         err_count <= 16'h0000;
      end else begin
         if (check_done && mismatch) begin
            error_flag <= 1'b1;
         end else if (apb_wr && PADDR_IN == STATUS_ADDR && PWDATA_IN[STAT_ERROR]) begin
            error_flag <= 1'b0;
         end
         if (check_done && mismatch && err_count != 16'hFFFF) begin
            err_count <= err_count + 16'h0001;
         end else if (apb_wr && PADDR_IN == ERRCNT_ADDR) begin
            err_count <= 16'h0000;
         end
      end
   end
endmodule : write_crc_x16_chop4_map
`default_nettype wire

// *** verification/crc_chop4_checker.sv ***
`default_nettype none
module crc_chop4_checker
   import crc_chop4_pkg::*;
(
   // Watched ports
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic PREADY_OUT,
   input wire logic PSLVERR_OUT,
   input wire logic BEAT_VALID_IN,
   input wire logic [CHOP_BEATS*DQ_LANES-1:0] DATA_OUT,
   input wire logic UPPER_HALF_OUT,
   input wire logic DATA_VALID_OUT,
   input wire logic CRC_ERROR_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Checks
   logic acc;
   logic mapped;
   assign acc = PSEL_IN && PENABLE_IN;
   assign mapped = PADDR_IN inside {CTRL_ADDR, STATUS_ADDR, CHECK_ADDR, ERRCNT_ADDR};
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   sequence s_result;
      DATA_VALID_OUT ##1 !DATA_VALID_OUT;
   endsequence
   AST_READY: assert property (PREADY_OUT) else $error("ready low");
   AST_ERR_UNMAPPED: assert property (PSLVERR_OUT |-> acc && !mapped)
      else $error("bad slave error");
   AST_MAPPED_OK: assert property (acc && mapped |-> !PSLVERR_OUT)
      else $error("error on mapped address");
   AST_UNMAPPED_ZERO: assert property (acc && !PWRITE_IN && !mapped |-> PRDATA_OUT == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_ERR_WITH_VALID: assert property (CRC_ERROR_OUT |-> DATA_VALID_OUT)
      else $error("error without result");
   AST_VALID_PULSE: assert property (DATA_VALID_OUT |-> s_result)
      else $error("result longer than a cycle");
   AST_VALID_AFTER_BEAT: assert property (DATA_VALID_OUT |-> $past(BEAT_VALID_IN, 2))
      else $error("result not after last beat");
   AST_DATA_HOLDS: assert property (!DATA_VALID_OUT |-> $stable(DATA_OUT) && $stable(UPPER_HALF_OUT))
      else $error("data changed without result");
endmodule : crc_chop4_checker
bind write_crc_x16_chop4_map crc_chop4_checker crc_chop4_checker_inst (.REF_CLK_IN, .RST_N_IN, .PSEL_IN,
   .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .BEAT_VALID_IN, .DATA_OUT,
   .UPPER_HALF_OUT, .DATA_VALID_OUT, .CRC_ERROR_OUT);
`default_nettype wire

// *** verification/ddr_ctrl_model.sv ***
`default_nettype none
module ddr_ctrl_model
   import crc_chop4_pkg::*;
(
   // Clock
   input wire logic clk_in,
   // Burst lines
   output logic start_out,
   output logic valid_out,
   output logic nib_out,
   output logic [15:0] dq_out,
   output logic lmi_out,
   output logic umi_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Tree and burst
   logic [15:0] last_crc;
   initial begin
      {start_out, valid_out, nib_out, lmi_out, umi_out} = 5'h00;
      dq_out = 16'h0000;
   end
   function automatic logic [7:0] tree(input logic [63:0] d, input logic [7:0] m, input logic en, input int t);
      logic [71:0] x;
      logic [7:0] c;
      x = '1;
      c = CRC_INIT;
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 8; j++) x[8*j+k] = d[16*k+8*t+j];
         x[64+k] = en ? m[2*k+t] : 1'b1;
      end
      for (int i = 71; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ x[i]) ? CRC_POLY : 8'h00);
      return c;
   endfunction : tree
   task automatic send(input logic [63:0] d, input logic [7:0] m, input logic a2, en, bad, gap);
      last_crc = {tree(d, m, en, 1), tree(d, m, en, 0)};
      for (int b = 0; b < 10; b++) begin
         @(posedge clk_in);
         if (b == 5 && gap) begin
            valid_out <= 1'b0;
            @(posedge clk_in);
         end
         start_out <= (b == 0);
         valid_out <= 1'b1;
         nib_out <= a2;
         dq_out <= b < 4 ? d[16*b+:16] : (b == 8 ? last_crc ^ 16'(bad) : 16'hFFFF);
         lmi_out <= b < 4 ? m[2*b] : 1'b1;
         umi_out <= b < 4 ? m[2*b+1] : 1'b1;
      end
      @(posedge clk_in);
      {start_out, valid_out} <= 2'h0;
      dq_out <= ~dq_out;
      {lmi_out, umi_out} <= ~{lmi_out, umi_out};
   endtask : send
endmodule : ddr_ctrl_model
`default_nettype wire

// *** verification/write_crc_x16_chop4_map_tb.sv ***
`default_nettype none
module write_crc_x16_chop4_map_tb
   import crc_chop4_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, penable, pwrite, start, vld, nib, lmi, umi, pready, pslverr, upper, dval, cerr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] dq;
   logic [63:0] rx_data;
   logic [7:0] rx_mask;
   logic [4:0] ctrl [4] = '{5'h03, 5'h0B, 5'h13, 5'h1B};
   int n_mismatch, num_checks;
   write_crc_x16_chop4_map write_crc_x16_chop4_map_inst (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .BURST_START_IN(start), .BEAT_VALID_IN(vld),
      .NIBBLE_SELECT_ADDR_BIT_IN(nib), .DQ_IN(dq), .LOWER_LANE_MASK_INVERT_IN(lmi),
      .UPPER_LANE_MASK_INVERT_IN(umi), .DATA_OUT(rx_data), .MASK_INVERT_OUT(rx_mask), .UPPER_HALF_OUT(upper),
      .DATA_VALID_OUT(dval), .CRC_ERROR_OUT(cerr));
   ddr_ctrl_model ddr_ctrl_model_inst (.clk_in(clk), .start_out(start), .valid_out(vld), .nib_out(nib),
      .dq_out(dq), .lmi_out(lmi), .umi_out(umi));
   // ==========================================
   // Tasks
   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   task chk(input logic [72:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int i;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) begin
         chk(0, 1);
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, exp);
   endtask : rd
   task burst(input logic [63:0] d, input logic [7:0] m, input logic a2, en, bad, gap, exp_v);
      logic seen;
      seen = 1'b0;
      ddr_ctrl_model_inst.send(d, m, a2, en, bad, gap);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk) #1;
         if (dval === 1'b1) begin
            seen = 1'b1;
            chk(cerr, bad);
            chk({rx_mask, upper, rx_data}, {m, a2, d});
         end
      end
      chk(seen, exp_v);
   endtask : burst
   // ==========================================
   // Sequence
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ctrl[n]) rd(12'h000 + 12'(4 * n), 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk({e, r}, {1'b1, 32'h0000_0000});
      $display("test reset done");
      burst(64'h0000_FFFF_1234_5678, 8'h0F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      apb(1'b1, CTRL_ADDR, 32'h0000_0001);
      burst(64'h0000_FFFF_1234_5678, 8'h0F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      apb(1'b1, CTRL_ADDR, 32'h0000_0007);
      burst(64'h0000_FFFF_1234_5678, 8'h0F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      $display("test inactive done");
      for (int n = 0; n < 4; n++) begin
         apb(1'b1, CTRL_ADDR, {27'h000_0000, ctrl[n]});
         rd(CTRL_ADDR, {27'h000_0000, ctrl[n]});
         burst(64'h0123_4567_89AB_CDEF + n, 8'h5A ^ 8'(n), n[0], ctrl[n][3] | ctrl[n][4], n == 2, n[1], 1'b1);
         rd(CHECK_ADDR, {ddr_ctrl_model_inst.last_crc ^ 16'(n == 2), ddr_ctrl_model_inst.last_crc});
      end
      $display("test modes done");
      rd(STATUS_ADDR, 32'h0000_0007);
      rd(ERRCNT_ADDR, 32'h0000_0001);
      apb(1'b1, STATUS_ADDR, 32'h0000_0001);
      rd(STATUS_ADDR, 32'h0000_0006);
      apb(1'b1, ERRCNT_ADDR, 32'h0000_0000);
      rd(ERRCNT_ADDR, 32'h0000_0000);
      $display("test status done");
      wrap_up();
   end
endmodule : write_crc_x16_chop4_map_tb
`default_nettype wire
